// *** core/hspi_defs.svh ***
`ifndef HSPI_DEFS_SVH
`define HSPI_DEFS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define HSPI_CLK_NS            50
`define HSPI_IRQ_RELEASE_NS    100000
`define HSPI_SWITCH_MAX_NS     8000
`define HSPI_SYNC_CYC          4

// ----------------------------------------------------------------------------
// Region count and frame layout
// ----------------------------------------------------------------------------
`define HSPI_REGIONS           3
`define HSPI_HDR_BITS          5'h08
`define HSPI_FRAME_BITS        5'h10
`define HSPI_HDR_RW_POS        7
`define HSPI_HDR_ADDR_MSB      6
`define HSPI_HDR_ADDR_LSB      2

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define HSPI_ADDR_IRQ_TOP      5'h10
`define HSPI_ADDR_SRC_BASE     5'h11
`define HSPI_ADDR_FLAG_BUS     5'h14
`define HSPI_ADDR_FLAG_TEMP    5'h15
`define HSPI_ADDR_FLAG_SUPPLY  5'h16
`define HSPI_ADDR_RESET_REASON 5'h17
`define HSPI_ADDR_CTRL         5'h18

// ----------------------------------------------------------------------------
// Reset values and unmapped read value
// ----------------------------------------------------------------------------
`define HSPI_PINS_RESET        4'hA
`define HSPI_CTRL_RESET        8'h00
`define HSPI_READ_UNMAPPED     8'h00

`endif

// *** core/hspi_pkg.sv ***
`include "hspi_defs.svh"

package hspi_pkg;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi_sda;
    logic iface_sel;
  } hspi_pins_type;

  typedef struct packed {
    logic [7:0] bus;
    logic [7:0] temp;
    logic [7:0] supply;
  } hspi_flags_type;

  typedef logic [`HSPI_REGIONS-1:0][7:0] hspi_src_type;

  // --------------------------------------------------------------------------
  // Frame phases
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    HSPI_IDLE   = 3'b001,
    HSPI_HEADER = 3'b010,
    HSPI_DATA   = 3'b100
  } hspi_phase_type;

  typedef struct packed {
    hspi_phase_type phase;
    logic           pol;
    logic [4:0]     bitcnt;
    logic           rw;
    logic [4:0]     addr;
    logic [7:0]     rx;
    logic [7:0]     tx;
    logic           cs_q;
    logic           sclk_q;
    logic           sel_twi;
    hspi_src_type   src;
    logic [7:0]     reason;
    logic [7:0]     ctrl;
    logic           rst_q;
    logic [15:0]    rel_cnt;
    logic           irq_n;
    logic           sdo;
    logic           sdo_oe_n;
    logic           sda_pin;
    logic           sda_oe_n;
    logic           scl_o;
    logic           sda_o;
  } hspi_state_type;

endpackage : hspi_pkg

// *** core/hspi_sync.sv ***
`timescale 1ns/1ns

module hspi_sync #(
  parameter int         W    = 4,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  // Raw and filtered levels
  input  wire logic [W-1:0] raw_in,
  output logic      [W-1:0] stable_out
);

  typedef struct packed {
    logic [W-1:0] q1;
    logic [W-1:0] q2;
    logic [W-1:0] q3;
    logic [W-1:0] val;
  } hspi_sync_state_type;

  hspi_sync_state_type s;
  hspi_sync_state_type next_s;

  initial
  begin
    if (W < 1)
    begin
      $error("hspi_sync needs at least one bit");
    end
  end

  // --------------------------------------------------------------------------
  // Three stages; a level counts only once the last two agree.
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_s     = s;
    next_s.q1  = raw_in;
    next_s.q2  = s.q1;
    next_s.q3  = s.q2;
    next_s.val = (~(s.q2 ^ s.q3) & s.q3) | ((s.q2 ^ s.q3) & s.val);
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s <= '{q1: INIT, q2: INIT, q3: INIT, val: INIT};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign stable_out = s.val;

endmodule : hspi_sync

// *** core/hspi_top.sv ***
`timescale 1ns/1ns
`include "hspi_defs.svh"

// Behaviour
// - Interrupt pin low while any flag set
// - Top-level bit clears with its sources
// - System reset clears all interrupt flags
// - Pin released for minimum time after clear
// - Source bits cleared by writing one
// - Region register over per-region source registers
// - Event during access is never lost
// - Flag status reads live, no side effect
// - Reset cause captured when reset asserts
// - Reading reset reason clears it
// - Select low SPI, high two-wire port
// - Clock and data pins shared, routed by select
// - Select stable during transfer; switch within 8us
// - Slave only, master starts every transfer
// - Clock level at select fall picks edges
// - Frame is header byte plus data byte
// - Write data follows header, MSB first
// - Read data driven after header, MSB first
// - Select rising ends the operation
module hspi_top #(
  parameter int IRQ_RELEASE_NS = `HSPI_IRQ_RELEASE_NS
) (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   arst_n_in,
  // Serial pins
  input  wire hspi_pkg::hspi_pins_type pins_in,
  output logic                        sdo_out,
  output logic                        sdo_oe_n_out,
  output logic                        sda_out,
  output logic                        sda_oe_n_out,
  // Two-wire engine side
  input  wire logic                   twi_sda_low_in,
  output logic                        twi_scl_out,
  output logic                        twi_sda_out,
  output logic                        twi_sel_out,
  // Interrupt sources and status
  input  wire hspi_pkg::hspi_src_type  irq_event_in,
  input  wire hspi_pkg::hspi_flags_type flags_in,
  output logic                        irq_out_n,
  // System reset
  input  wire logic                   sys_rst_n_in,
  input  wire logic [7:0]             reset_cause_in,
  // Control
  output logic [7:0]                  ctrl_out
);

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int          REL_CYC_I  = (IRQ_RELEASE_NS + `HSPI_CLK_NS - 1) / `HSPI_CLK_NS;
  localparam logic [15:0] REL_CYC    = 16'(REL_CYC_I);
  localparam int          SWITCH_CYC = `HSPI_SWITCH_MAX_NS / `HSPI_CLK_NS;

  initial
  begin
    if (REL_CYC_I < 1 || REL_CYC_I > 65535)
    begin
      $error("irq release time does not fit the counter");
    end
    if (SWITCH_CYC < `HSPI_SYNC_CYC)
    begin
      $error("port switch cannot meet its bound");
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [3:0] pins_raw;
  logic [3:0] pins_st;
  logic       cs_n;
  logic       sclk;
  logic       sdi;
  logic       sel;

  assign pins_raw = {pins_in.cs_n, pins_in.sclk, pins_in.sdi_sda, pins_in.iface_sel};

  hspi_sync #(
    .W    (4),
    .INIT (`HSPI_PINS_RESET)
  ) u_sync (
    .clk_in     (clk_in),
    .arst_n_in  (arst_n_in),
    .raw_in     (pins_raw),
    .stable_out (pins_st)
  );

  assign cs_n = pins_st[3];
  assign sclk = pins_st[2];
  assign sdi  = pins_st[1];
  assign sel  = pins_st[0];

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  hspi_pkg::hspi_state_type s;
  hspi_pkg::hspi_state_type next_s;

  logic                  cs_fall;
  logic                  cs_rise;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  samp_edge;
  logic                  shift_edge;
  logic [7:0]            hdr;
  logic [4:0]            hdr_addr;
  logic [7:0]            rd_data;
  logic                  wr_commit;
  logic                  reason_clr;
  hspi_pkg::hspi_src_type wr_clr;
  logic                  any_cleared;
  logic                  any_set;

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  always_comb
  begin
    hdr      = {s.rx[6:0], sdi};
    hdr_addr = (s.phase == hspi_pkg::HSPI_HEADER) ?
               hdr[`HSPI_HDR_ADDR_MSB:`HSPI_HDR_ADDR_LSB] : s.addr;
    rd_data  = `HSPI_READ_UNMAPPED;
    case (hdr_addr)
      `HSPI_ADDR_IRQ_TOP:
      begin
        for (int r = 0; r < `HSPI_REGIONS; r++)
        begin
          rd_data[r] = |s.src[r];
        end
      end
      `HSPI_ADDR_SRC_BASE:      rd_data = s.src[0];
      `HSPI_ADDR_SRC_BASE + 5'h01: rd_data = s.src[1];
      `HSPI_ADDR_SRC_BASE + 5'h02: rd_data = s.src[2];
      `HSPI_ADDR_FLAG_BUS:      rd_data = flags_in.bus;
      `HSPI_ADDR_FLAG_TEMP:     rd_data = flags_in.temp;
      `HSPI_ADDR_FLAG_SUPPLY:   rd_data = flags_in.supply;
      `HSPI_ADDR_RESET_REASON:  rd_data = s.reason;
      `HSPI_ADDR_CTRL:          rd_data = s.ctrl;
      default:                  rd_data = `HSPI_READ_UNMAPPED;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_s      = s;
    cs_fall     = s.cs_q & ~cs_n;
    cs_rise     = ~s.cs_q & cs_n;
    sclk_rise   = ~s.sclk_q & sclk;
    sclk_fall   = s.sclk_q & ~sclk;
    samp_edge   = s.pol ? sclk_rise : sclk_fall;
    shift_edge  = s.pol ? sclk_fall : sclk_rise;
    wr_commit   = 1'b0;
    reason_clr  = 1'b0;
    wr_clr      = '0;
    any_cleared = 1'b0;
    any_set     = 1'b0;

    next_s.cs_q   = cs_n;
    next_s.sclk_q = sclk;

    // Switching mid-frame would tear the frame, so the port only follows the
    // select pin between frames.
    if (s.phase == hspi_pkg::HSPI_IDLE && cs_n)
    begin
      next_s.sel_twi = sel;
    end

    case (s.phase)
      hspi_pkg::HSPI_IDLE:
      begin
        if (!s.sel_twi && cs_fall)
        begin
          next_s.pol    = sclk;
          next_s.bitcnt = 5'h00;
          next_s.phase  = hspi_pkg::HSPI_HEADER;
        end
      end
      hspi_pkg::HSPI_HEADER:
      begin
        if (samp_edge)
        begin
          next_s.rx     = hdr;
          next_s.bitcnt = s.bitcnt + 5'h01;
          if (s.bitcnt == `HSPI_HDR_BITS - 5'h01)
          begin
            next_s.rw    = hdr[`HSPI_HDR_RW_POS];
            next_s.addr  = hdr_addr;
            next_s.phase = hspi_pkg::HSPI_DATA;
            if (hdr[`HSPI_HDR_RW_POS])
            begin
              next_s.tx  = rd_data;
              next_s.sdo = rd_data[7];
              reason_clr = (hdr_addr == `HSPI_ADDR_RESET_REASON);
            end
          end
        end
      end
      hspi_pkg::HSPI_DATA:
      begin
        if (samp_edge && s.bitcnt < `HSPI_FRAME_BITS)
        begin
          next_s.rx     = hdr;
          next_s.bitcnt = s.bitcnt + 5'h01;
        end
        if (shift_edge && s.rw && s.bitcnt > `HSPI_HDR_BITS && s.bitcnt < `HSPI_FRAME_BITS)
        begin
          next_s.sdo = s.tx[6];
          next_s.tx  = {s.tx[6:0], 1'b0};
        end
      end
      default:
      begin
        next_s.phase = hspi_pkg::HSPI_IDLE;
      end
    endcase

    if (s.phase != hspi_pkg::HSPI_IDLE && cs_rise)
    begin
      wr_commit    = (s.phase == hspi_pkg::HSPI_DATA) && !s.rw &&
                     (s.bitcnt == `HSPI_FRAME_BITS);
      next_s.phase = hspi_pkg::HSPI_IDLE;
    end

    // Register writes land only on a complete frame.
    if (wr_commit)
    begin
      for (int r = 0; r < `HSPI_REGIONS; r++)
      begin
        if (s.addr == `HSPI_ADDR_SRC_BASE + 5'(r))
        begin
          wr_clr[r] = s.rx;
        end
      end
      if (s.addr == `HSPI_ADDR_CTRL)
      begin
        next_s.ctrl = s.rx;
      end
    end

    // Interrupt sources: a new event outweighs a clear in the same cycle.
    for (int r = 0; r < `HSPI_REGIONS; r++)
    begin
      any_cleared    = any_cleared | (|(s.src[r] & wr_clr[r]));
      next_s.src[r]  = (s.src[r] & ~wr_clr[r]) | irq_event_in[r];
      if (!sys_rst_n_in)
      begin
        next_s.src[r] = 8'h00;
      end
      any_set        = any_set | (|next_s.src[r]);
    end

    // The pin is held high for the release time so edge-triggered hosts see
    // a fresh falling edge when flags are still or again pending.
    if (!sys_rst_n_in)
    begin
      next_s.rel_cnt = 16'h0000;
    end
    else if (any_cleared)
    begin
      next_s.rel_cnt = REL_CYC;
    end
    else if (s.rel_cnt != 16'h0000)
    begin
      next_s.rel_cnt = s.rel_cnt - 16'h0001;
    end
    next_s.irq_n = (next_s.rel_cnt != 16'h0000) || !any_set;

    // Reset reason: a capture wins over a clear by read.
    next_s.rst_q = sys_rst_n_in;
    if (reason_clr)
    begin
      next_s.reason = 8'h00;
    end
    if (s.rst_q && !sys_rst_n_in)
    begin
      next_s.reason = reset_cause_in;
    end

    // Pin routing.
    next_s.sdo_oe_n = !(next_s.phase == hspi_pkg::HSPI_DATA && next_s.rw &&
                        !s.sel_twi);
    next_s.scl_o    = s.sel_twi ? sclk : 1'b1;
    next_s.sda_o    = s.sel_twi ? sdi : 1'b1;
    next_s.sda_oe_n = !(s.sel_twi && twi_sda_low_in);
    next_s.sda_pin  = 1'b0;
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s          <= '0;
      s.phase    <= hspi_pkg::HSPI_IDLE;
      s.cs_q     <= 1'b1;
      s.ctrl     <= `HSPI_CTRL_RESET;
      s.rst_q    <= 1'b1;
      s.irq_n    <= 1'b1;
      s.sdo_oe_n <= 1'b1;
      s.sda_oe_n <= 1'b1;
      s.scl_o    <= 1'b1;
      s.sda_o    <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign sdo_out      = s.sdo;
  assign sdo_oe_n_out = s.sdo_oe_n;
  assign sda_out      = s.sda_pin;
  assign sda_oe_n_out = s.sda_oe_n;
  assign twi_scl_out  = s.scl_o;
  assign twi_sda_out  = s.sda_o;
  assign twi_sel_out  = s.sel_twi;
  assign irq_out_n    = s.irq_n;
  assign ctrl_out     = s.ctrl;

endmodule : hspi_top

// *** verification/hspi_top_asserts.sv ***
`timescale 1ns/1ns
`include "hspi_defs.svh"

module hspi_top_asserts #(
  parameter int IRQ_RELEASE_NS = `HSPI_IRQ_RELEASE_NS
) (
  // Watched ports
  input wire logic                    clk_in,
  input wire logic                    arst_n_in,
  input wire hspi_pkg::hspi_pins_type pins_in,
  input wire logic                    sdo_oe_n_out,
  input wire logic                    sda_out,
  input wire logic                    sda_oe_n_out,
  input wire logic                    twi_sda_low_in,
  input wire logic                    twi_scl_out,
  input wire logic                    twi_sda_out,
  input wire logic                    twi_sel_out,
  input wire hspi_pkg::hspi_src_type  irq_event_in,
  input wire logic                    irq_out_n,
  input wire logic                    sys_rst_n_in
);
  localparam int REL    = IRQ_RELEASE_NS / `HSPI_CLK_NS;
  localparam int SW_MAX = `HSPI_SWITCH_MAX_NS / `HSPI_CLK_NS;

  // A system reset cancels the release window, so a fall right after it is legal.
  logic [15:0] hi_cnt;
  logic        sr_seen;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      hi_cnt  <= 16'h0000;
      sr_seen <= 1'b1;
    end
    else
    begin
      hi_cnt  <= !irq_out_n ? 16'h0000 : hi_cnt + {15'h0000, hi_cnt != 16'hFFFF};
      sr_seen <= !sys_rst_n_in || (sr_seen && irq_out_n);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sys_reset_clear_a: assert property (!sys_rst_n_in |=> irq_out_n)
    else $error("Interrupt output low after system reset");
  irq_hold_a: assert property (!irq_out_n && !pins_in.cs_n && !$past(pins_in.cs_n, 8)
    && sys_rst_n_in |=> !irq_out_n) else $error("Interrupt output released mid frame");
  irq_set_a: assert property (sys_rst_n_in && (|irq_event_in) && hi_cnt >= REL
    |-> ##[1:2] !irq_out_n) else $error("Interrupt output not asserted after event");
  irq_release_a: assert property ($fell(irq_out_n) |-> sr_seen || hi_cnt >= REL)
    else $error("Interrupt output high time too short");
  sdo_release_a: assert property (pins_in.cs_n && $past(pins_in.cs_n, 8) |-> sdo_oe_n_out)
    else $error("Data output driven while deselected");
  twi_quiet_a: assert property (twi_sel_out |-> sdo_oe_n_out)
    else $error("Data output driven in two-wire mode");
  sda_drive_a: assert property (!sda_oe_n_out |-> !sda_out && twi_sel_out
    && $past(twi_sda_low_in)) else $error("Shared data pin pulled without request");
  sel_switch_a: assert property (pins_in.cs_n && pins_in.iface_sel != twi_sel_out
    |-> ##[1:SW_MAX] twi_sel_out == pins_in.iface_sel) else $error("Port switch too slow");
  twi_idle_a: assert property (!twi_sel_out && !$past(twi_sel_out)
    |-> twi_scl_out && twi_sda_out) else $error("Two-wire lines not idle in SPI mode");
endmodule : hspi_top_asserts

bind hspi_top hspi_top_asserts #(.IRQ_RELEASE_NS(IRQ_RELEASE_NS)) u_asserts (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .pins_in(pins_in), .sdo_oe_n_out(sdo_oe_n_out),
  .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .twi_sda_low_in(twi_sda_low_in),
  .twi_scl_out(twi_scl_out), .twi_sda_out(twi_sda_out), .twi_sel_out(twi_sel_out),
  .irq_event_in(irq_event_in), .irq_out_n(irq_out_n), .sys_rst_n_in(sys_rst_n_in));

// *** verification/hspi_spi_master.sv ***
`timescale 1ns/1ns

module hspi_spi_master (
  // Serial lines
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      sdi_out,
  input  wire logic sdo_in
);
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b1;
    sdi_out  = 1'b0;
  end

  // Fewer than sixteen bits model an aborted frame.
  task automatic xfer(input logic pol, input logic rw, input logic [4:0] addr,
                      input logic [7:0] wd, input int nbits, output logic [7:0] rd);
    logic [15:0] frame;
    frame    = {rw, addr, 2'b00, wd};
    rd       = 8'h00;
    sclk_out = pol;
    #407;
    cs_n_out = 1'b0;
    #400;
    for (int i = 15; i > 15 - nbits; i--)
    begin
      sclk_out = ~pol;
      sdi_out  = frame[i];
      #200;
      sclk_out = pol;
      #200;
      // The device output lags its synchronisers, so bits are taken late in the phase.
      if (i < 8)
        rd = {rd[6:0], sdo_in};
    end
    #200;
    cs_n_out = 1'b1;
    sdi_out  = ~sdi_out;
    #600;
  endtask : xfer
endmodule : hspi_spi_master

// *** verification/host_spi_irq_interface_tb_top.sv ***
`timescale 1ns/1ns
`include "hspi_defs.svh"

module host_spi_irq_interface_tb_top;
  logic                     clk_in = 1'b0;
  logic                     arst_n_in = 1'b0;
  logic                     cs_n, sclk, sdi, sdo_out, sdo_oe_n_out, sda_out, sda_oe_n_out;
  logic                     iface_sel = 1'b0;
  logic                     twi_sda_low_in = 1'b0;
  logic                     sys_rst_n_in = 1'b1;
  logic                     twi_scl_out, twi_sda_out, twi_sel_out, irq_out_n;
  logic [7:0]               reset_cause_in = 8'h00;
  logic [7:0]               ctrl_out, r;
  hspi_pkg::hspi_pins_type  pins_in;
  hspi_pkg::hspi_src_type   irq_event_in = '0;
  hspi_pkg::hspi_flags_type flags_in = '0;
  int                       n_mismatch = 0;
  int                       checks_done = 0;
  localparam logic [4:0]    SRC = `HSPI_ADDR_SRC_BASE;

  // The shared data pin is open drain: the device can only pull it low.
  assign pins_in = {cs_n, sclk, sdi & (sda_oe_n_out | sda_out), iface_sel};
  always #25 clk_in = ~clk_in;

  hspi_spi_master m (.cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi),
                     .sdo_in(sdo_oe_n_out ? 1'bz : sdo_out));
  hspi_top #(.IRQ_RELEASE_NS(1000)) dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .pins_in(pins_in), .sdo_out(sdo_out), .sdo_oe_n_out(sdo_oe_n_out), .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out), .twi_sda_low_in(twi_sda_low_in), .twi_scl_out(twi_scl_out),
    .twi_sda_out(twi_sda_out), .twi_sel_out(twi_sel_out), .irq_event_in(irq_event_in),
    .flags_in(flags_in), .irq_out_n(irq_out_n), .sys_rst_n_in(sys_rst_n_in),
    .reset_cause_in(reset_cause_in), .ctrl_out(ctrl_out));

  task automatic finish_test();
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc

  task automatic rd(input logic [4:0] a, input logic pol, input logic [7:0] e);
    m.xfer(pol, 1'b1, a, 8'h00, 16, r);
    chk(r, e);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic pol);
    m.xfer(pol, 1'b0, a, d, 16, r);
  endtask : wr

  task automatic pulse(input int g, input int b);
    @(negedge clk_in);
    irq_event_in[g][b] = 1'b1;
    @(negedge clk_in);
    irq_event_in = '0;
  endtask : pulse

  // A wait that runs out ends the run at once.
  task automatic wait_irq(input logic v);
    for (int i = 0; i < 100 && irq_out_n !== v; i++)
      @(negedge clk_in);
    chk({7'h00, irq_out_n}, {7'h00, v});
    if (irq_out_n !== v)
      finish_test();
  endtask : wait_irq

  task automatic t_rw();
    chk({irq_out_n, sdo_oe_n_out, twi_sel_out, 5'h00}, 8'hC0);
    wr(`HSPI_ADDR_CTRL, 8'hA5, 1'b1);
    chk(ctrl_out, 8'hA5);
    rd(`HSPI_ADDR_CTRL, 1'b0, 8'hA5);
    wr(`HSPI_ADDR_CTRL, 8'h5A, 1'b0);
    rd(`HSPI_ADDR_CTRL, 1'b1, 8'h5A);
    rd(5'h1F, 1'b1, `HSPI_READ_UNMAPPED);
    m.xfer(1'b1, 1'b0, `HSPI_ADDR_CTRL, 8'h3C, 15, r);
    m.xfer(1'b0, 1'b0, `HSPI_ADDR_CTRL, 8'hC3, 9, r);
    chk(ctrl_out, 8'h5A);
  endtask : t_rw

  task automatic t_irq();
    pulse(1, 2);
    wait_irq(1'b0);
    rd(`HSPI_ADDR_IRQ_TOP, 1'b1, 8'h02);
    rd(SRC + 5'h01, 1'b0, 8'h04);
    wr(SRC + 5'h01, 8'h00, 1'b1);
    rd(SRC + 5'h01, 1'b1, 8'h04);
    fork
      m.xfer(1'b1, 1'b1, SRC + 5'h02, 8'h00, 16, r);
      begin
        cyc(60);
        pulse(2, 7);
      end
    join
    chk(r, 8'h80);
    rd(SRC + 5'h02, 1'b1, 8'h80);
    rd(`HSPI_ADDR_IRQ_TOP, 1'b1, 8'h06);
    wr(SRC + 5'h01, 8'h04, 1'b1);
    chk({7'h00, irq_out_n}, 8'h01);
    wait_irq(1'b0);
    wr(SRC + 5'h02, 8'h80, 1'b0);
    wait_irq(1'b1);
    rd(`HSPI_ADDR_IRQ_TOP, 1'b1, 8'h00);
  endtask : t_irq

  task automatic t_status();
    @(negedge clk_in);
    flags_in = {8'h81, 8'h42, 8'h24};
    for (int k = 0; k < 6; k++)
      rd(`HSPI_ADDR_FLAG_BUS + 5'(k % 3), k[0], flags_in[23 - 8 * (k % 3) -: 8]);
    pulse(0, 0);
    reset_cause_in = 8'hC3;
    sys_rst_n_in   = 1'b0;
    cyc(4);
    sys_rst_n_in   = 1'b1;
    reset_cause_in = 8'h00;
    wait_irq(1'b1);
    rd(SRC, 1'b1, 8'h00);
    rd(`HSPI_ADDR_RESET_REASON, 1'b0, 8'hC3);
    rd(`HSPI_ADDR_RESET_REASON, 1'b1, 8'h00);
  endtask : t_status

  task automatic t_twi();
    @(negedge clk_in);
    iface_sel      = 1'b1;
    twi_sda_low_in = 1'b1;
    cyc(`HSPI_SWITCH_MAX_NS / `HSPI_CLK_NS);
    chk({twi_sel_out, sda_oe_n_out, sda_out, 5'h00}, 8'h80);
    @(negedge clk_in);
    twi_sda_low_in = 1'b0;
    m.xfer(1'b0, 1'b0, `HSPI_ADDR_CTRL, 8'h10, 16, r);
    chk(ctrl_out, 8'h5A);
    chk({sdo_oe_n_out, twi_scl_out, twi_sda_out, 5'h00}, 8'hA0);
    @(negedge clk_in);
    iface_sel = 1'b0;
    cyc(`HSPI_SWITCH_MAX_NS / `HSPI_CLK_NS);
    chk({7'h00, twi_sel_out}, 8'h00);
  endtask : t_twi

  initial
  begin
    cyc(16);
    arst_n_in = 1'b1;
    cyc(12);
    t_rw();
    t_irq();
    t_status();
    t_twi();
    finish_test();
  end
endmodule : host_spi_irq_interface_tb_top
